/* rtl/smf_pkg.sv */
// constants and types shared by the serial memory front end
package smf_pkg;

  localparam int unsigned ADDR_W     = 17;
  localparam int unsigned MEM_DEPTH  = 131072;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_BYTES = 3;
  localparam int unsigned SCK_MAX_MHZ = 40;
  localparam int unsigned SYNC_W     = 4;

  // sync vector bit positions
  localparam int unsigned SY_SEL   = 0;
  localparam int unsigned SY_MODE3 = 1;
  localparam int unsigned SY_WROTE = 2;
  localparam int unsigned SY_BAD   = 3;

  // command opcodes
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WREN  = 8'h06;

  // status register layout
  localparam int unsigned ST_WEL  = 1;
  localparam int unsigned ST_BP0  = 2;
  localparam int unsigned ST_BP1  = 3;
  localparam int unsigned ST_WPEN = 7;
  localparam logic [7:0]  ST_WR_MASK = 8'h8C;
  localparam logic [7:0]  ST_RESET   = 8'h40;

  // block protect boundaries on the top two address bits
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] TOP_QUARTER = 2'h3;

  localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  typedef enum logic [2:0] {
    PH_OPC,
    PH_ADDR,
    PH_WR,
    PH_RD,
    PH_SWR,
    PH_SRD,
    PH_IGN
  } smf_phase_t;

endpackage : smf_pkg

/* rtl/smf_sync.sv */
// two flip-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module smf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } smf_sync_t;

  smf_sync_t s_r;
  smf_sync_t s_nxt;

  always_comb begin
    s_nxt.meta = i_d;
    s_nxt.q    = s_r.meta;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.q;

endmodule : smf_sync

/* rtl/smf_mem.sv */
// byte array: write on rising serial clock, asynchronous read
`timescale 1ns/100ps
module smf_mem #(
  parameter int unsigned ADDR_W = 17,
  parameter int unsigned DEPTH  = 131072,
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [ADDR_W-1:0] i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);

  // nonvolatile contents: no reset on purpose
  logic [DATA_W-1:0] mem_r [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // read is combinational so the first bit leaves on the very next fall
  assign o_rdata = mem_r[i_raddr];

endmodule : smf_mem

/* rtl/smf_spi_front.sv */
// spi slave front end of a byte wide serial nonvolatile memory
// Summary of operation
// - sample input on rising edges after select
// - output changes on falling clock edges or at deselect
// - only spi modes 0 and 3 supported
// - clock level at select picks mode
// - mode 3 ignores idle high level
// - first byte after select is opcode
// - one opcode per select period
// - all bytes shifted msb first
// - three address bytes, seventeen bits used
// - first seven address bits are ignored
// - bad opcode ignores input until reselect
// - deselected: ignore input, output released
// - array is 131072 bytes of eight
// - writes finish at serial bus speed
// - eight bit status register configures device
// - input and output may share one wire
// - drive output only for read data
`timescale 1ns/100ps
module smf_spi_front #(
  parameter int unsigned ADDR_W = smf_pkg::ADDR_W,
  parameter int unsigned DEPTH  = smf_pkg::MEM_DEPTH
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_si,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_selected,
  output logic      o_mode3,
  output logic      o_write_frame,
  output logic      o_bad_opcode
);
  import smf_pkg::*;

  // state of the serial clock domain, cleared while deselected
  typedef struct packed {
    smf_phase_t        ph;
    logic [2:0]        bitc;
    logic [1:0]        bytec;
    logic [6:0]        sh;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        tx;
    logic              rd;
    logic              wrote;
    logic              bad;
  } smf_link_t;

  typedef struct packed {
    logic so;
    logic oe;
  } smf_out_t;

  typedef struct packed {
    logic sel;
    logic mode3;
    logic wrote_d;
    logic bad_d;
    logic write_frame;
    logic bad_pulse;
  } smf_sys_t;

  smf_link_t         lk_r;
  smf_link_t         lk_nxt;
  smf_out_t          out_r;
  smf_out_t          out_nxt;
  smf_sys_t          sys_r;
  smf_sys_t          sys_nxt;
  logic [7:0]        st_r;
  logic [7:0]        st_nxt;
  logic              mode3_cap_r;

  logic [7:0]        bit_in;
  logic [ADDR_W-1:0] addr_sh;
  logic [ADDR_W-1:0] mem_raddr;
  logic [7:0]        mem_q;
  logic              mem_we;
  logic              byte_end;
  logic              st_we;
  logic              wel_set;
  logic              wel_clr;
  logic              wr_ok;
  logic [1:0]        bp;
  logic [1:0]        top;
  logic              prot;
  logic [SYNC_W-1:0] sy_in;
  logic [SYNC_W-1:0] sy_q;

  // block protection on the upper quarter, half or whole array
  always_comb begin
    bp   = {st_r[ST_BP1], st_r[ST_BP0]};
    top  = lk_r.addr[ADDR_W-1 -: 2];
    prot = (bp == 2'h3) ||
           (bp == BP_HALF && top[1]) ||
           (bp == BP_QUARTER && top == TOP_QUARTER);
    wr_ok = st_r[ST_WEL] && !prot;
  end

  // link domain, rising edges of the serial clock
  always_comb begin
    bit_in    = {lk_r.sh, i_si};
    addr_sh   = {lk_r.addr[ADDR_W-2:0], i_si};
    byte_end  = (lk_r.bitc == LAST_BIT);
    lk_nxt    = lk_r;
    lk_nxt.sh = bit_in[6:0];
    lk_nxt.bitc = lk_r.bitc + 3'h1;
    mem_we    = 1'b0;
    st_we     = 1'b0;
    wel_set   = 1'b0;
    wel_clr   = 1'b0;
    mem_raddr = (lk_r.ph == PH_ADDR) ? addr_sh : lk_r.addr;
    case (lk_r.ph)
      PH_OPC: begin
        if (byte_end) begin
          case (bit_in)
            OP_READ: begin
              lk_nxt.ph = PH_ADDR;
              lk_nxt.rd = 1'b1;
            end
            OP_WRITE: begin
              lk_nxt.ph = PH_ADDR;
              lk_nxt.rd = 1'b0;
            end
            OP_RDSR: begin
              lk_nxt.ph = PH_SRD;
              lk_nxt.tx = st_r;
            end
            OP_WRSR: begin
              lk_nxt.ph = PH_SWR;
            end
            OP_WREN: begin
              wel_set   = 1'b1;
              lk_nxt.ph = PH_IGN;
            end
            OP_WRDI: begin
              wel_clr   = 1'b1;
              lk_nxt.ph = PH_IGN;
            end
            default: begin
              lk_nxt.bad = 1'b1;
              lk_nxt.ph  = PH_IGN;
            end
          endcase
        end
      end
      PH_ADDR: begin
        // upper bits simply fall off the top of the shifter
        lk_nxt.addr = addr_sh;
        if (byte_end) begin
          lk_nxt.bytec = lk_r.bytec + 2'h1;
          if (lk_r.bytec == LAST_ADDR_BYTE) begin
            if (lk_r.rd) begin
              lk_nxt.ph   = PH_RD;
              lk_nxt.tx   = mem_q;
              lk_nxt.addr = addr_sh + ADDR_W'(1);
            end else begin
              lk_nxt.ph = PH_WR;
            end
          end
        end
      end
      PH_WR: begin
        if (byte_end) begin
          // committed on the edge that completes the byte
          mem_we       = wr_ok;
          lk_nxt.wrote = lk_r.wrote | wr_ok;
          lk_nxt.addr  = lk_r.addr + ADDR_W'(1);
        end
      end
      PH_RD: begin
        if (byte_end) begin
          lk_nxt.tx   = mem_q;
          lk_nxt.addr = lk_r.addr + ADDR_W'(1);
        end
      end
      PH_SWR: begin
        if (byte_end) begin
          st_we     = st_r[ST_WEL];
          lk_nxt.ph = PH_IGN;
        end
      end
      PH_SRD: begin
        if (byte_end) begin
          lk_nxt.tx = st_r;
        end
      end
      default: begin
        // ignored until the next select, one opcode per frame
        lk_nxt.ph = PH_IGN;
      end
    endcase
  end

  // deselect is the frame reset; in mode 3 no rising edge comes at select
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // status register survives deselect, WEL and the fixed bits are read only
  always_comb begin
    st_nxt = st_r;
    if (st_we) begin
      st_nxt = (st_r & ~ST_WR_MASK) | (bit_in & ST_WR_MASK);
    end
    if (wel_set) begin
      st_nxt[ST_WEL] = 1'b1;
    end else if (wel_clr) begin
      st_nxt[ST_WEL] = 1'b0;
    end
  end

  always_ff @(posedge i_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // output only while returning data, so a shared data wire is safe
  always_comb begin
    out_nxt.oe = (lk_r.ph == PH_RD) || (lk_r.ph == PH_SRD);
    out_nxt.so = lk_r.tx[LAST_BIT - lk_r.bitc];
  end

  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  // clock level seen at the select edge chooses the mode
  always_ff @(negedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode3_cap_r <= 1'b0;
    end else begin
      mode3_cap_r <= i_sck;
    end
  end

  smf_mem #(
    .ADDR_W (ADDR_W),
    .DEPTH  (DEPTH),
    .DATA_W (DATA_W)
  ) u_mem (
    .i_clk   (i_sck),
    .i_we    (mem_we),
    .i_waddr (lk_r.addr),
    .i_wdata (bit_in),
    .i_raddr (mem_raddr),
    .o_rdata (mem_q)
  );

  // system clock side: frame levels cross as levels, edges found here
  always_comb begin
    sy_in           = '0;
    sy_in[SY_SEL]   = ~i_cs_n;
    sy_in[SY_MODE3] = mode3_cap_r;
    sy_in[SY_WROTE] = lk_r.wrote;
    sy_in[SY_BAD]   = lk_r.bad;
  end

  smf_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (sy_in),
    .o_q     (sy_q)
  );

  always_comb begin
    sys_nxt.sel         = sy_q[SY_SEL];
    sys_nxt.mode3       = sy_q[SY_MODE3];
    sys_nxt.wrote_d     = sy_q[SY_WROTE];
    sys_nxt.bad_d       = sy_q[SY_BAD];
    sys_nxt.write_frame = sy_q[SY_WROTE] && !sys_r.wrote_d;
    sys_nxt.bad_pulse   = sy_q[SY_BAD] && !sys_r.bad_d;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sys_r <= '0;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign o_so          = out_r.so;
  assign o_so_oe       = out_r.oe;
  assign o_selected    = sys_r.sel;
  assign o_mode3       = sys_r.mode3;
  assign o_write_frame = sys_r.write_frame;
  assign o_bad_opcode  = sys_r.bad_pulse;

endmodule : smf_spi_front

/* test/smf_spi_front_properties.sv */
// port assertions for the serial memory front end
`timescale 1ns/100ps
module smf_spi_front_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_selected,
  input wire logic o_mode3,
  input wire logic o_write_frame,
  input wire logic o_bad_opcode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_OE_IDLE: assert property (i_cs_n |-> !o_so_oe)
    else $error("output driven while deselected");
  AST_SEL_ON: assert property ($fell(i_cs_n) |-> ##[1:5] o_selected)
    else $error("select not seen");
  AST_SEL_OFF: assert property ($rose(i_cs_n) |-> ##[1:5] !o_selected)
    else $error("deselect not seen");
  AST_WF_ONE: assert property (o_write_frame |=> !o_write_frame)
    else $error("write pulse too long");
  AST_BAD_ONE: assert property (o_bad_opcode |=> !o_bad_opcode)
    else $error("bad opcode pulse too long");
  AST_BAD_NO_OE: assert property (o_bad_opcode |-> !o_so_oe)
    else $error("output driven after bad opcode");
  AST_WF_SEL: assert property (o_write_frame |-> o_selected)
    else $error("write pulse outside frame");
  AST_MODE_HOLD: assert property (o_selected && $past(o_selected)
    |-> $stable(o_mode3))
    else $error("mode changed inside frame");
endmodule : smf_spi_front_properties

bind smf_spi_front smf_spi_front_properties i_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .o_selected(o_selected),
  .o_mode3(o_mode3), .o_write_frame(o_write_frame),
  .o_bad_opcode(o_bad_opcode));

/* test/smf_spi_master.sv */
// spi master model for the front end link
`timescale 1ns/100ps
module smf_spi_master (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  logic last;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    last = 1'b0;
    // one deselect edge while reset is low, so link flops leave unknown
    #2 o_cs_n = 1'b0;
    #3 o_cs_n = 1'b1;
  end

  task automatic start(input logic m3);
    o_sck = m3;
    // odd offset keeps link edges off the system clock edges
    #21 o_cs_n = 1'b0;
    #20;
  endtask : start

  // released output reads as the inverse of its last level
  task automatic xfer(input int n, input logic [7:0] tx,
                      output logic [7:0] rx);
    logic b;
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      o_sck = 1'b0;
      o_si = tx[7-i];
      #6;
      b = i_so_oe ? i_so : ~last;
      last = b;
      rx = {rx[6:0], b};
      o_sck = 1'b1;
      // bench link period is fixed; the logic itself has no speed floor
      #6;
    end
  endtask : xfer

  // select stays low long enough for the system side pulses
  task automatic stop(input logic m3);
    #6 o_sck = m3;
    #40 o_cs_n = 1'b1;
    o_si = ~o_si;
    // frame length stays a multiple of 4 ns, so the offset is kept
    #41;
  endtask : stop
endmodule : smf_spi_master

/* test/testbench.sv */
// self-checking bench for the serial memory front end
`timescale 1ns/100ps
module testbench;
  import smf_pkg::*;
  typedef struct packed {
    logic m3; logic [7:0] op; logic [23:0] adr; logic [7:0] d;
  } smf_row_t;
  localparam smf_row_t ROWS [5] = '{
    '{1'b0, OP_WRITE, 24'hFE0010, 8'hA5},
    '{1'b1, OP_WRITE, 24'h000011, 8'h3C},
    '{1'b0, OP_READ,  24'h000010, 8'hA5},
    '{1'b1, OP_READ,  24'hFE0011, 8'h3C},
    '{1'b0, OP_WRITE, 24'h020000, 8'h5A}};
  localparam logic [7:0] ST_WE = ST_RESET | 8'h02;
  logic clk, rst_n, sck, cs_n, si, so, so_oe, sel, mode3, wf, bad;
  logic [15:0] rd;
  logic [7:0]  r;
  int n_fail, tests_run, n_wf, n_bad, n_oe, cyc;

  smf_spi_front i_smf_spi_front (.i_clk(clk), .i_rst_n(rst_n),
    .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe),
    .o_selected(sel), .o_mode3(mode3), .o_write_frame(wf),
    .o_bad_opcode(bad));
  smf_spi_master i_smf_spi_master (.o_sck(sck), .o_cs_n(cs_n),
    .o_si(si), .i_so(so), .i_so_oe(so_oe));

  always #4 clk = ~clk;

  // outputs are counted half a cycle after they launch
  always @(negedge clk) begin
    cyc++;
    if (wf === 1'b1) n_wf++;
    if (bad === 1'b1) n_bad++;
    if (so_oe === 1'b1) n_oe++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic frame(input logic m3, input logic [7:0] op,
                       input logic [23:0] adr, input int nd,
                       input logic [15:0] wd);
    rd = 16'h0000;
    i_smf_spi_master.start(m3);
    i_smf_spi_master.xfer(8, op, r);
    chk(mode3, m3);
    if (op == OP_READ || op == OP_WRITE)
      for (int i = 2; i >= 0; i--)
        i_smf_spi_master.xfer(8, adr[8*i+:8], r);
    for (int i = nd - 1; i >= 0; i--) begin
      i_smf_spi_master.xfer(8, wd[8*i+:8], r);
      rd[8*i+:8] = r;
    end
    i_smf_spi_master.stop(m3);
  endtask : frame

  initial begin
    clk = 1'b0;
    // a real falling edge, so the asynchronous resets are seen
    rst_n = 1'b1;
    #1 rst_n = 1'b0;
    {n_fail, tests_run, n_wf, n_bad, n_oe, cyc} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({sel, mode3, so_oe, wf, bad}, 16'h0000);
    repeat (2) @(negedge clk);
    foreach (ROWS[k]) begin
      frame(1'b0, OP_WREN, 24'h0, 0, 16'h0);
      frame(ROWS[k].m3, ROWS[k].op, ROWS[k].adr, 1, {8'h00, ROWS[k].d});
      if (ROWS[k].op == OP_READ) chk(rd[7:0], ROWS[k].d);
    end
    frame(1'b0, OP_READ, 24'h000000, 1, 16'h0);
    chk(rd[7:0], 8'h5A);
    chk(n_wf[7:0], 8'h03);
    // two bytes across the top of the array
    frame(1'b1, OP_WRITE, 24'h01FFFF, 2, 16'h1122);
    frame(1'b0, OP_READ, 24'h01FFFF, 2, 16'h0);
    chk(rd, 16'h1122);
    frame(1'b0, OP_RDSR, 24'h0, 2, 16'h0);
    chk(rd, {ST_WE, ST_WE});
    chk(n_oe > 0, 1'b1);
    // a second opcode in the same frame must not start a read
    n_oe = 0;
    frame(1'b0, OP_WRDI, 24'h0, 2, {OP_READ, 8'h00});
    chk(n_oe[7:0], 8'h00);
    frame(1'b0, 8'hAB, 24'h0, 2, {OP_RDSR, 8'h00});
    chk(n_oe[7:0], 8'h00);
    chk(n_bad[7:0], 8'h01);
    i_smf_spi_master.start(1'b0);
    i_smf_spi_master.xfer(4, OP_READ, r);
    i_smf_spi_master.stop(1'b0);
    frame(1'b0, OP_RDSR, 24'h0, 1, 16'h0);
    chk(rd[7:0], ST_RESET);
    conclude();
  end
endmodule : testbench
